// ---- logic/sml_shift_engine.sv ----
// Link-clock shift engine: one serial clock edge per link clock cycle.
// Assumes the bundle in the carrier is stable whenever go_tgl changes.
`timescale 1ns/1ns
module sml_shift_engine
  import sml_pkg::*;
(
  input  wire logic link_clk, // link clock
  input  wire logic rstn,     // reset, sys side, active low
  sml_xfer_if.eng   xif,      // carrier to register side
  output logic      sclk_o,   // serial clock pin value
  output logic      mosi_o,   // data out pin value
  input  wire logic miso_i    // data in pin, asynchronous
);

  logic [1:0]            rst_sync_ff;
  logic [3:0]            sync1_ff;
  logic [3:0]            sync2_ff;
  logic                  go_prev_ff,   nxt_go_prev;
  sml_state_e            state_ff,     nxt_state;
  logic [SML_EDGE_W-1:0] edge_ff,      nxt_edge;
  logic [SML_EDGE_W-1:0] last_ff,      nxt_last;
  sml_word_t             sh_ff,        nxt_sh;
  sml_word_t             rx_ff,        nxt_rx;
  logic                  cpha_ff,      nxt_cpha;
  logic                  lb_ff,        nxt_lb;
  logic                  sclk_int_ff,  nxt_sclk_int;
  logic                  mosi_int_ff,  nxt_mosi_int;
  logic                  sclk_pin_ff,  nxt_sclk_pin;
  logic                  mosi_pin_ff,  nxt_mosi_pin;
  logic                  done_tgl_ff,  nxt_done_tgl;
  logic [1:0]            pend_ff,      nxt_pend;
  logic                  lrst_n;
  logic                  go_s, cpol_s, lb_s, miso_s;
  logic                  din, freeze;
  logic [SML_CNT_W-1:0]  n_bits;
  sml_word_t             preload;

  // Reset and pin inputs each pass two flops
  always_ff @(posedge link_clk)
  begin
    rst_sync_ff <= {rst_sync_ff[0], rstn};
    sync1_ff    <= {xif.go_tgl, xif.cpol_live, xif.lb_live, miso_i};
    sync2_ff    <= sync1_ff;
  end
  assign lrst_n = rst_sync_ff[1];
  assign {go_s, cpol_s, lb_s, miso_s} = sync2_ff;

  assign n_bits  = (xif.nbits < SML_MIN_BITS) ? SML_MIN_BITS :
                   (xif.nbits > SML_MAX_BITS) ? SML_MAX_BITS : xif.nbits;
  assign preload = xif.tx_word << (SML_MAX_BITS - n_bits);
  assign din     = lb_ff ? mosi_int_ff : miso_s;
  assign freeze  = lb_s | ((state_ff != SML_IDLE) & lb_ff);

  always_comb
  begin
    nxt_go_prev  = go_s;
    nxt_state    = state_ff;
    nxt_edge     = edge_ff;
    nxt_last     = last_ff;
    nxt_sh       = sh_ff;
    nxt_rx       = rx_ff;
    nxt_cpha     = cpha_ff;
    nxt_lb       = lb_ff;
    nxt_sclk_int = sclk_int_ff;
    nxt_mosi_int = mosi_int_ff;
    nxt_done_tgl = done_tgl_ff;
    nxt_pend     = {pend_ff[0], 1'b0};
    // Pin data lags two sync flops, so it is taken two cycles late
    if (pend_ff[1])
    begin
      nxt_rx = {rx_ff[SML_WORD_W-2:0], din};
    end
    case (state_ff)
      SML_IDLE:
      begin
        nxt_sclk_int = cpol_s;
        if (go_s != go_prev_ff)
        begin
          nxt_cpha  = xif.cpha;
          nxt_lb    = xif.lb;
          nxt_last  = SML_EDGE_W'({n_bits, 1'b0} - 6'h01);
          nxt_edge  = '0;
          nxt_rx    = '0;
          nxt_state = SML_SHIFT;
          // Phase 0 presents the first bit before the first edge
          if (!xif.cpha)
          begin
            nxt_mosi_int = preload[SML_WORD_W-1];
            nxt_sh       = {preload[SML_WORD_W-2:0], 1'b0};
          end
          else
          begin
            nxt_sh = preload;
          end
        end
      end
      SML_SHIFT:
      begin
        nxt_sclk_int = ~sclk_int_ff;
        nxt_edge     = edge_ff + 6'h01;
        if (edge_ff[0] == cpha_ff)
        begin
          if (lb_ff)
          begin
            nxt_rx = {rx_ff[SML_WORD_W-2:0], din};
          end
          else
          begin
            nxt_pend[0] = 1'b1;
          end
        end
        else
        begin
          nxt_mosi_int = sh_ff[SML_WORD_W-1];
          nxt_sh       = {sh_ff[SML_WORD_W-2:0], 1'b0};
        end
        if (edge_ff == last_ff)
        begin
          nxt_state = SML_DONE;
        end
      end
      SML_DONE:
      begin
        // Hold the end until the late pin samples are in
        if (pend_ff == 2'h0)
        begin
          nxt_done_tgl = ~done_tgl_ff;
          nxt_state    = SML_IDLE;
        end
      end
      default:
      begin
        nxt_state = SML_IDLE;
      end
    endcase
    nxt_sclk_pin = freeze ? sclk_pin_ff : nxt_sclk_int;
    nxt_mosi_pin = freeze ? mosi_pin_ff : nxt_mosi_int;
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      go_prev_ff  <= 1'b0;
      state_ff    <= SML_IDLE;
      edge_ff     <= '0;
      last_ff     <= '0;
      sh_ff       <= '0;
      rx_ff       <= '0;
      cpha_ff     <= 1'b0;
      lb_ff       <= 1'b0;
      sclk_int_ff <= SML_SCLK_RST;
      mosi_int_ff <= 1'b0;
      sclk_pin_ff <= SML_SCLK_RST;
      mosi_pin_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      pend_ff     <= 2'h0;
    end
    else
    begin
      go_prev_ff  <= nxt_go_prev;
      state_ff    <= nxt_state;
      edge_ff     <= nxt_edge;
      last_ff     <= nxt_last;
      sh_ff       <= nxt_sh;
      rx_ff       <= nxt_rx;
      cpha_ff     <= nxt_cpha;
      lb_ff       <= nxt_lb;
      sclk_int_ff <= nxt_sclk_int;
      mosi_int_ff <= nxt_mosi_int;
      sclk_pin_ff <= nxt_sclk_pin;
      mosi_pin_ff <= nxt_mosi_pin;
      done_tgl_ff <= nxt_done_tgl;
      pend_ff     <= nxt_pend;
    end
  end

  assign xif.done_tgl = done_tgl_ff;
  assign xif.rx_word  = rx_ff;
  assign sclk_o       = sclk_pin_ff;
  assign mosi_o       = mosi_pin_ff;

endmodule : sml_shift_engine

// ---- logic/sml_pkg.sv ----
// Package for the SPI master with loopback: execute bits, sizes, states.
// Assumes both clock domains import it; no timing counts are needed.
package sml_pkg;

  // Execute register fields
  localparam int unsigned SML_GO_BIT   = 0;
  localparam int unsigned SML_SS_BIT   = 1;
  localparam int unsigned SML_EXEC_W   = 8;

  // Transfer sizes
  localparam int unsigned SML_WORD_W   = 24;
  localparam int unsigned SML_CNT_W    = 5;
  localparam int unsigned SML_EDGE_W   = 6;
  localparam logic [4:0]  SML_MIN_BITS = 5'h01;
  localparam logic [4:0]  SML_MAX_BITS = 5'h18;

  // Reset values
  localparam logic        SML_SS_RST   = 1'b1;
  localparam logic        SML_SCLK_RST = 1'b0;

  typedef logic [SML_WORD_W-1:0] sml_word_t;

  typedef enum logic [1:0] {
    SML_IDLE,
    SML_SHIFT,
    SML_DONE
  } sml_state_e;

endpackage : sml_pkg

// ---- logic/sml_xfer_if.sv ----
// Carrier between the register side and the link-side shift engine.
// Bundle words are held stable by the register side while a toggle travels.
`timescale 1ns/1ns
interface sml_xfer_if;
  import sml_pkg::*;

  logic                 go_tgl;
  logic                 done_tgl;
  logic                 cpol;
  logic                 cpha;
  logic [SML_CNT_W-1:0] nbits;
  sml_word_t            tx_word;
  logic                 lb;
  sml_word_t            rx_word;
  logic                 cpol_live;
  logic                 lb_live;

  modport ctrl (
    output go_tgl, cpol, cpha, nbits, tx_word, lb, cpol_live, lb_live,
    input  done_tgl, rx_word
  );
  modport eng (
    input  go_tgl, cpol, cpha, nbits, tx_word, lb, cpol_live, lb_live,
    output done_tgl, rx_word
  );
endinterface : sml_xfer_if

// ---- logic/sml_spi_master.sv ----
// Register side of the SPI master with loopback, on sys_clk.
// Assumes a free-running link clock; the shift engine runs on it.
`timescale 1ns/1ns

// Contract
// - Each transfer moves 1 to 24 bits, set by the bit count field.
// - Outbound word sits in three bytes, low byte least significant.
// - Execute value 0x01 drives select low and launches the transfer.
// - Execute value 0x02 drives select high without starting a transfer.
// - Captured bits land in three inbound bytes, read after completion.
// - A loopback test is enabled by a diagnostic control bit.
// - In loopback the outbound bits feed the data input internally.
// - In loopback clock, data out and select pins hold their state.
// - A loopback transfer copies the outbound bytes into the inbound ones; the code copies only the low bit-count bits, higher bits read 0.
// - Select pin keeps the level programmed when loopback was entered.
// - Pins are driven only while the port enable is set.
// - Polarity sets the idle clock level; phase picks the sampling edge.
// - The device makes the serial clock and drives select.
module sml_spi_master
  import sml_pkg::*;
(
  input  wire logic                  sys_clk,            // system clock, 100 MHz
  input  wire logic                  rstn,               // sync reset, active low
  input  wire logic                  link_clk,           // link clock for shifting
  input  wire logic                  cfg_cpol,           // clock polarity
  input  wire logic                  cfg_cpha,           // clock phase
  input  wire logic [SML_CNT_W-1:0]  transfer_bit_count, // bits per transfer
  input  wire logic [7:0]            outbound_byte_low,  // tx bits 7:0
  input  wire logic [7:0]            outbound_byte_mid,  // tx bits 15:8
  input  wire logic [7:0]            outbound_byte_high, // tx bits 23:16
  input  wire logic                  exec_wr,            // execute write strobe
  input  wire logic [SML_EXEC_W-1:0] exec_data,          // execute write value
  input  wire logic                  loopback_en,        // loopback test enable
  input  wire logic                  port_en,            // pins taken over
  output logic      [7:0]            inbound_byte_low,   // rx bits 7:0
  output logic      [7:0]            inbound_byte_mid,   // rx bits 15:8
  output logic      [7:0]            inbound_byte_high,  // rx bits 23:16
  output logic                       busy,               // launch bit
  output logic                       xfer_done,          // end of transfer pulse
  output logic                       ss_level,           // programmed select level
  output logic                       sclk_o,             // serial clock out
  output logic                       sclk_oe,            // serial clock enable
  output logic                       mosi_o,             // data out
  output logic                       mosi_oe,            // data out enable
  input  wire logic                  miso_i,             // data in pin
  output logic                       ss_o,               // select out
  output logic                       ss_oe               // select enable
);

  sml_xfer_if xif ();

  logic                 done_s1_ff;
  logic                 done_s2_ff;
  logic                 done_prev_ff,  nxt_done_prev;
  logic                 go_ff,         nxt_go;
  logic                 ss_ctrl_ff,    nxt_ss_ctrl;
  logic                 ss_pin_ff,     nxt_ss_pin;
  logic                 go_tgl_ff,     nxt_go_tgl;
  logic                 cpol_h_ff,     nxt_cpol_h;
  logic                 cpha_h_ff,     nxt_cpha_h;
  logic [SML_CNT_W-1:0] nbits_h_ff,    nxt_nbits_h;
  sml_word_t            tx_h_ff,       nxt_tx_h;
  logic                 lb_h_ff,       nxt_lb_h;
  sml_word_t            rx_ff,         nxt_rx;
  logic                 done_ff,       nxt_done;
  logic                 done_edge;
  logic                 miso_gated;

  // Done toggle crosses in two flops
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
    end
    else
    begin
      done_s1_ff <= xif.done_tgl;
      done_s2_ff <= done_s1_ff;
    end
  end
  assign done_edge = done_s2_ff ^ done_prev_ff;

  always_comb
  begin
    nxt_done_prev = done_s2_ff;
    nxt_go        = go_ff;
    nxt_ss_ctrl   = ss_ctrl_ff;
    nxt_go_tgl    = go_tgl_ff;
    nxt_cpol_h    = cpol_h_ff;
    nxt_cpha_h    = cpha_h_ff;
    nxt_nbits_h   = nbits_h_ff;
    nxt_tx_h      = tx_h_ff;
    nxt_lb_h      = lb_h_ff;
    nxt_rx        = rx_ff;
    nxt_done      = 1'b0;
    if (exec_wr)
    begin
      nxt_ss_ctrl = exec_data[SML_SS_BIT];
      if (exec_data[SML_GO_BIT] && !go_ff)
      begin
        nxt_go      = 1'b1;
        nxt_go_tgl  = ~go_tgl_ff;
        nxt_cpol_h  = cfg_cpol;
        nxt_cpha_h  = cfg_cpha;
        nxt_nbits_h = transfer_bit_count;
        nxt_tx_h    = {outbound_byte_high, outbound_byte_mid, outbound_byte_low};
        nxt_lb_h    = loopback_en;
      end
    end
    // Launch cannot coincide: go is only accepted while idle
    if (done_edge && go_ff)
    begin
      nxt_go   = 1'b0;
      nxt_rx   = xif.rx_word;
      nxt_done = 1'b1;
    end
  end

  always_comb
  begin
    nxt_ss_pin = loopback_en ? ss_pin_ff : ss_ctrl_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      done_prev_ff <= 1'b0;
      go_ff        <= 1'b0;
      ss_ctrl_ff   <= SML_SS_RST;
      ss_pin_ff    <= SML_SS_RST;
      go_tgl_ff    <= 1'b0;
      cpol_h_ff    <= 1'b0;
      cpha_h_ff    <= 1'b0;
      nbits_h_ff   <= SML_MIN_BITS;
      tx_h_ff      <= '0;
      lb_h_ff      <= 1'b0;
      rx_ff        <= '0;
      done_ff      <= 1'b0;
    end
    else
    begin
      done_prev_ff <= nxt_done_prev;
      go_ff        <= nxt_go;
      ss_ctrl_ff   <= nxt_ss_ctrl;
      ss_pin_ff    <= nxt_ss_pin;
      go_tgl_ff    <= nxt_go_tgl;
      cpol_h_ff    <= nxt_cpol_h;
      cpha_h_ff    <= nxt_cpha_h;
      nbits_h_ff   <= nxt_nbits_h;
      tx_h_ff      <= nxt_tx_h;
      lb_h_ff      <= nxt_lb_h;
      rx_ff        <= nxt_rx;
      done_ff      <= nxt_done;
    end
  end

  // Bundle is held until the next launch, so the engine reads it safely
  assign xif.go_tgl    = go_tgl_ff;
  assign xif.cpol      = cpol_h_ff;
  assign xif.cpha      = cpha_h_ff;
  assign xif.nbits     = nbits_h_ff;
  assign xif.tx_word   = tx_h_ff;
  assign xif.lb        = lb_h_ff;
  assign xif.cpol_live = cfg_cpol;
  assign xif.lb_live   = loopback_en;

  assign miso_gated = miso_i & port_en;

  sml_shift_engine u_engine (
    .link_clk (link_clk),
    .rstn     (rstn),
    .xif      (xif.eng),
    .sclk_o   (sclk_o),
    .mosi_o   (mosi_o),
    .miso_i   (miso_gated)
  );

  assign inbound_byte_low  = rx_ff[7:0];
  assign inbound_byte_mid  = rx_ff[15:8];
  assign inbound_byte_high = rx_ff[23:16];
  assign busy              = go_ff;
  assign xfer_done         = done_ff;
  assign ss_level          = ss_ctrl_ff;
  assign ss_o              = ss_pin_ff;
  assign sclk_oe           = port_en;
  assign mosi_oe           = port_en;
  assign ss_oe             = port_en;

endmodule : sml_spi_master

// ---- test/sml_spi_monitor.sv ----
// Checker for the SPI master: launch, select, done and pin enables.
// Assumes it is bound onto sml_spi_master and sees only its ports.
`timescale 1ns/1ns
module sml_spi_monitor
  import sml_pkg::*;
(
  input wire logic                  sys_clk,     // system clock
  input wire logic                  rstn,        // sync reset, active low
  input wire logic                  exec_wr,     // execute strobe
  input wire logic [SML_EXEC_W-1:0] exec_data,   // execute value
  input wire logic                  loopback_en, // loopback enable
  input wire logic                  port_en,     // pin takeover
  input wire logic                  busy,        // launch bit
  input wire logic                  xfer_done,   // end pulse
  input wire logic                  ss_level,    // programmed select
  input wire logic                  sclk_o,      // clock pin
  input wire logic                  sclk_oe,     // clock enable
  input wire logic                  mosi_o,      // data out pin
  input wire logic                  mosi_oe,     // data out enable
  input wire logic                  ss_o,        // select pin
  input wire logic                  ss_oe        // select enable
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_launch_busy:
    assert property (exec_wr && exec_data[SML_GO_BIT] && !busy |=> busy)
    else $error("launch did not raise busy");
  a_select_taken:
    assert property (exec_wr |=> ss_level == $past(exec_data[SML_SS_BIT]))
    else $error("select level not taken");
  a_deselect_idle:
    assert property (exec_wr && exec_data == 8'h02 && !busy |=> !busy)
    else $error("deselect started a transfer");
  a_done_busy:
    assert property (xfer_done |-> $fell(busy))
    else $error("done without busy falling");
  a_done_pulse:
    assert property (xfer_done |=> !xfer_done)
    else $error("done longer than one cycle");
  a_busy_bound:
    assert property ($rose(busy) |-> ##[1:400] xfer_done)
    else $error("transfer never finished");
  a_pin_enables:
    assert property (sclk_oe == port_en && mosi_oe == port_en && ss_oe == port_en)
    else $error("pin enable differs from port enable");
  a_loop_freeze:
    assert property (loopback_en && $past(loopback_en) |->
      $stable(sclk_o) && $stable(mosi_o) && $stable(ss_o))
    else $error("pin moved in loopback");
  a_ss_follow:
    assert property ((exec_wr && !loopback_en) ##1 (!exec_wr && !loopback_en) [*2]
      |-> ss_o == $past(exec_data[SML_SS_BIT], 2))
    else $error("select pin not following");
endmodule : sml_spi_monitor

bind sml_spi_master sml_spi_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn),
  .exec_wr(exec_wr), .exec_data(exec_data), .loopback_en(loopback_en), .port_en(port_en),
  .busy(busy), .xfer_done(xfer_done), .ss_level(ss_level), .sclk_o(sclk_o),
  .sclk_oe(sclk_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .ss_o(ss_o), .ss_oe(ss_oe));

// ---- test/sml_slave_model.sv ----
// Behavioural SPI slave on the master pins, any polarity and phase.
// Assumes the bench gives it the same polarity and phase as the master.
`timescale 1ns/1ns
module sml_slave_model
  import sml_pkg::*;
(
  input  wire logic      sclk,  // serial clock pin
  input  wire logic      mosi,  // data from master
  input  wire logic      ss_n,  // select, active low
  input  wire logic      cpol,  // idle clock level
  input  wire logic      cpha,  // sampling edge choice
  input  wire sml_word_t reply, // reply, sent from bit 23 down
  output logic           miso,  // data to master
  output sml_word_t      got    // bits taken in, last in bit 0
);
  sml_word_t sh;

  initial
  begin
    miso = 1'b0;
    got  = '0;
    sh   = '0;
  end

  always @(negedge ss_n)
  begin
    sh  = reply;
    got = '0;
    if (!cpha)
    begin
      miso = sh[23];
      sh   = sh << 1;
    end
  end

  // sample on one edge, shift on the other
  always @(sclk)
    if (!ss_n)
    begin
      if ((sclk != cpol) ^ cpha)
        got = {got[22:0], mosi};
      else
      begin
        miso = sh[23];
        sh   = sh << 1;
      end
    end

  // Released line must not look like held data
  always @(posedge ss_n)
    miso = ~miso;
endmodule : sml_slave_model

// ---- test/tb_top.sv ----
// Self-checking bench for the SPI master with loopback.
// Assumes the slave model on the pins and the bound checker.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module tb_top;
  import sml_pkg::*;

  logic                 sys_clk, link_clk, rstn, cfg_cpol, cfg_cpha, exec_wr, loopback_en;
  logic                 port_en, busy, xfer_done, ss_level, sclk_o, sclk_oe, mosi_o;
  logic                 mosi_oe, miso_i, ss_o, ss_oe, ss_w;
  logic [SML_CNT_W-1:0] cnt;
  logic [7:0]           ob_lo, ob_mid, ob_hi, ib_lo, ib_mid, ib_hi, exec_data;
  sml_word_t            reply, got;
  int                   error_cnt, tests_run;

  sml_spi_master dut (.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk),
    .cfg_cpol(cfg_cpol), .cfg_cpha(cfg_cpha), .transfer_bit_count(cnt),
    .outbound_byte_low(ob_lo), .outbound_byte_mid(ob_mid), .outbound_byte_high(ob_hi),
    .exec_wr(exec_wr), .exec_data(exec_data), .loopback_en(loopback_en), .port_en(port_en),
    .inbound_byte_low(ib_lo), .inbound_byte_mid(ib_mid), .inbound_byte_high(ib_hi),
    .busy(busy), .xfer_done(xfer_done), .ss_level(ss_level), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i), .ss_o(ss_o),
    .ss_oe(ss_oe));
  // Select line pulled up while the port is released
  assign ss_w = ss_oe ? ss_o : 1'b1;
  sml_slave_model slave (.sclk(sclk_o), .mosi(mosi_o), .ss_n(ss_w), .cpol(cfg_cpol),
    .cpha(cfg_cpha), .reply(reply), .miso(miso_i), .got(got));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic exec(input logic [7:0] v);
    @(posedge sys_clk);
    exec_wr   <= 1'b1;
    exec_data <= v;
    @(posedge sys_clk);
    exec_wr   <= 1'b0;
  endtask : exec

  task automatic run(input logic [4:0] n, input int m, input sml_word_t tx, rp, input bit poke);
    int        e;
    int        k;
    sml_word_t msk;
    logic [2:0] pins;
    sml_word_t  want;
    e   = (n == 0) ? 1 : (n > 24) ? 24 : n;
    msk = (sml_word_t'(1) << e) - 1;
    k   = 0;
    @(posedge sys_clk);
    cfg_cpol <= m[1];
    cfg_cpha <= m[0];
    cnt      <= n;
    {ob_hi, ob_mid, ob_lo} <= tx;
    reply    <= rp << (24 - e);
    repeat (20) @(posedge link_clk);
    #1;
    pins = {sclk_o, mosi_o, ss_o};
    if (!loopback_en) `CHK("idle sclk", m[1], sclk_o)
    exec(8'h01);
    if (poke)
    begin
      exec(8'h01);
      {ob_hi, ob_mid, ob_lo} <= ~tx;
    end
    @(posedge sys_clk);
    #1;
    `CHK("busy", 1'b1, busy)
    // wait for the end before reading
    while (xfer_done !== 1'b1 && k < 1000)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    `CHK("done", 1'b0, busy)
    want = loopback_en ? tx & msk : (port_en ? rp & msk : '0);
    `CHK("rx", want, {ib_hi, ib_mid, ib_lo})
    if (port_en && !loopback_en) `CHK("slave got", tx & msk, got)
    if (port_en && !loopback_en) `CHK("ss low", 1'b0, ss_o)
    exec(8'h02);
    @(posedge sys_clk);
    #1;
    if (!loopback_en) `CHK("ss high", 1'b1, ss_o)
    if (loopback_en) `CHK("frozen pins", pins, {sclk_o, mosi_o, ss_o})
    $display("test n=%0d mode=%0d loop=%0d port=%0d done", n, m, loopback_en, port_en);
  endtask : run

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    {rstn, exec_wr, cfg_cpol, cfg_cpha, loopback_en, cnt, exec_data} = '0;
    {ob_lo, ob_mid, ob_hi, reply, error_cnt, tests_run} = '0;
    port_en = 1'b1;
    repeat (10) @(posedge link_clk);
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge link_clk);
    #1;
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset ss", 1'b1, ss_o)
    `CHK("reset rx", 24'h00_0000, {ib_hi, ib_mid, ib_lo})
    $display("test reset done");
    // every mode, boundary and clipped counts
    run(5'd1, 0, 24'h00_0001, 24'h00_0001, 1'b0);
    run(5'd8, 1, 24'h12_34A5, 24'h00_005C, 1'b0);
    run(5'd24, 2, 24'hC3_5A96, 24'h96_A53C, 1'b1);
    run(5'd13, 3, 24'h00_1B6D, 24'h00_0A71, 1'b0);
    run(5'd0, 2, 24'hFF_FFFE, 24'h00_0001, 1'b0);
    run(5'd31, 1, 24'h81_4224, 24'h7E_BDDB, 1'b0);
    @(posedge sys_clk);
    port_en <= 1'b0;
    run(5'd8, 1, 24'h00_00F0, 24'h00_00FF, 1'b0);
    @(posedge sys_clk);
    port_en <= 1'b1;
    exec(8'h00);
    repeat (3) @(posedge sys_clk);
    // loopback entered with format already set
    loopback_en <= 1'b1;
    run(5'd13, 1, 24'h00_1ACE, 24'h00_0555, 1'b0);
    run(5'd24, 1, 24'hA5_0F3C, 24'h12_3456, 1'b0);
    @(posedge sys_clk);
    loopback_en <= 1'b0;
    run(5'd5, 1, 24'h00_0015, 24'h00_000A, 1'b0);
    end_of_test();
  end
endmodule : tb_top
